// ---- common/jts_consts.svh ----
// Constants for the test access port block: instruction codes, widths,
// capture pattern and synchroniser reset level.
// Assumes it is included by bare name from the package and the modules.
//
// Functional notes
// - Bypass code inserts one-bit bypass register
// - All-ones instruction scan decodes as bypass
// - Identification code shifts identification register out
// - Sample serial input on test-clock rising edges
// - Serial output changes on test-clock falling edges
// - Serial output high-impedance unless shifting
// - Power-up reset resets test port; no pin
// - Subset instructions, still proper chain member
// - Pins dedicated to test by default
// - Disabled test function turns pins into GPIO
// - Pin logic stays usable as buried logic
`ifndef JTS_CONSTS_SVH
`define JTS_CONSTS_SVH

`define JTS_IR_W          4
`define JTS_ID_W          32
`define JTS_IR_BYPASS     4'hF
`define JTS_IR_IDCODE     4'h1
`define JTS_IR_CAPTURE    4'h1
`define JTS_BYPASS_CAP    1'h0
`define JTS_SYNC_RESET    4'hF

`endif

// ---- common/jts_pkg.sv ----
// Types of the test access port block: controller states, pin bundle and
// the register images of both modules.
// Assumes jts_consts.svh is reachable on the include path.
`include "jts_consts.svh"

package jts_pkg;

    typedef enum logic [3:0] {
        st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr,
        st_ex2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir,
        st_ex2_ir, st_upd_ir
    } jts_tap_state_t;

    // One bit per test-port pin slot
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic tdo;
    } jts_pins_t;

    typedef struct packed {
        jts_pins_t meta;
        jts_pins_t stable;
    } jts_sync_state_t;

    typedef struct packed {
        jts_tap_state_t             tap;
        logic [`JTS_IR_W-1:0]       ir;
        logic [`JTS_IR_W-1:0]       ir_sh;
        logic [`JTS_ID_W-1:0]       dr_sh;
        logic                       tck_prev;
        logic                       dedicated;
        jts_pins_t                  pin_out;
        jts_pins_t                  pin_oe_n;
        jts_pins_t                  gpio_in;
    } jts_state_t;

endpackage

// ---- src/jts_sync.sv ----
// Two-stage synchroniser for the four test-port pin inputs.
// Assumes pins are asynchronous to ref_clk; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
`include "jts_consts.svh"

module jts_sync (
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire jts_pkg::jts_pins_t d,
    output jts_pkg::jts_pins_t  q
);

    jts_pkg::jts_sync_state_t st;
    jts_pkg::jts_sync_state_t next_st;

    always_comb begin
        next_st.meta   = d;
        next_st.stable = st.meta;
    end

    // Resets to high, the idle level of pulled-up test pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {`JTS_SYNC_RESET, `JTS_SYNC_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stable;

endmodule
`default_nettype wire

// ---- src/jts_tap.sv ----
// Test access port with bypass and identification instructions, sampled
// off the system clock, plus the pin-sharing logic for the four port pins.
// Assumes ref_clk is well above four times the test clock rate and that
// cfg_jtag_off comes from configuration logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "jts_consts.svh"

module jts_tap #(
    // Arbitrary identification value; bit 0 set as the chain protocol demands
    parameter logic [`JTS_ID_W-1:0] ID_VALUE = 32'h0ABC_D001
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               cfg_jtag_off,
    input  wire jts_pkg::jts_pins_t pin_in,
    output jts_pkg::jts_pins_t      pin_out,
    output jts_pkg::jts_pins_t      pin_oe_n,
    input  wire jts_pkg::jts_pins_t user_out,
    input  wire jts_pkg::jts_pins_t user_oe_n,
    output jts_pkg::jts_pins_t      gpio_in,
    output jts_pkg::jts_tap_state_t tap_state,
    output logic [`JTS_IR_W-1:0]    instr
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Standard sixteen-state walk, advanced on test-clock rising edges
    function automatic jts_pkg::jts_tap_state_t tap_next(
        input jts_pkg::jts_tap_state_t s,
        input logic                    tms
    );
        jts_pkg::jts_tap_state_t n;
        n = s;
        case (s)
            jts_pkg::st_reset:  n = tms ? jts_pkg::st_reset  : jts_pkg::st_idle;
            jts_pkg::st_idle:   n = tms ? jts_pkg::st_sel_dr : jts_pkg::st_idle;
            jts_pkg::st_sel_dr: n = tms ? jts_pkg::st_sel_ir : jts_pkg::st_cap_dr;
            jts_pkg::st_cap_dr: n = tms ? jts_pkg::st_ex1_dr : jts_pkg::st_sh_dr;
            jts_pkg::st_sh_dr:  n = tms ? jts_pkg::st_ex1_dr : jts_pkg::st_sh_dr;
            jts_pkg::st_ex1_dr: n = tms ? jts_pkg::st_upd_dr : jts_pkg::st_pa_dr;
            jts_pkg::st_pa_dr:  n = tms ? jts_pkg::st_ex2_dr : jts_pkg::st_pa_dr;
            jts_pkg::st_ex2_dr: n = tms ? jts_pkg::st_upd_dr : jts_pkg::st_sh_dr;
            jts_pkg::st_upd_dr: n = tms ? jts_pkg::st_sel_dr : jts_pkg::st_idle;
            jts_pkg::st_sel_ir: n = tms ? jts_pkg::st_reset  : jts_pkg::st_cap_ir;
            jts_pkg::st_cap_ir: n = tms ? jts_pkg::st_ex1_ir : jts_pkg::st_sh_ir;
            jts_pkg::st_sh_ir:  n = tms ? jts_pkg::st_ex1_ir : jts_pkg::st_sh_ir;
            jts_pkg::st_ex1_ir: n = tms ? jts_pkg::st_upd_ir : jts_pkg::st_pa_ir;
            jts_pkg::st_pa_ir:  n = tms ? jts_pkg::st_ex2_ir : jts_pkg::st_pa_ir;
            jts_pkg::st_ex2_ir: n = tms ? jts_pkg::st_upd_ir : jts_pkg::st_sh_ir;
            jts_pkg::st_upd_ir: n = tms ? jts_pkg::st_sel_dr : jts_pkg::st_idle;
            default:            n = jts_pkg::st_reset;
        endcase
        return n;
    endfunction

    // Only the identification code is decoded; every other code is bypass
    function automatic logic sel_id(input logic [`JTS_IR_W-1:0] ir);
        return ir == `JTS_IR_IDCODE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    jts_pkg::jts_pins_t sync_pins;

    jts_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (pin_in),
        .q       (sync_pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    jts_pkg::jts_state_t st;
    jts_pkg::jts_state_t next_st;

    logic tck_rise;
    logic tck_fall;

    assign tck_rise = sync_pins.tck & ~st.tck_prev;
    assign tck_fall = ~sync_pins.tck & st.tck_prev;

    always_comb begin
        next_st           = st;
        next_st.tck_prev  = sync_pins.tck;
        // Pin levels always reach the fabric, so the pin cells stay usable
        next_st.gpio_in   = sync_pins;
        next_st.dedicated = ~cfg_jtag_off;

        if (!st.dedicated) begin
            // Port held in reset while the pins serve as general I/O
            next_st.tap      = jts_pkg::st_reset;
            next_st.ir       = `JTS_IR_IDCODE;
            next_st.pin_out  = user_out;
            next_st.pin_oe_n = user_oe_n;
        end else begin
            // Input slots never driven while dedicated
            next_st.pin_out.tck  = 1'b0;
            next_st.pin_out.tms  = 1'b0;
            next_st.pin_out.tdi  = 1'b0;
            next_st.pin_oe_n.tck = 1'b1;
            next_st.pin_oe_n.tms = 1'b1;
            next_st.pin_oe_n.tdi = 1'b1;

            if (tck_rise) begin
                case (st.tap)
                    jts_pkg::st_reset: begin
                        next_st.ir = `JTS_IR_IDCODE;
                    end
                    jts_pkg::st_cap_ir: begin
                        next_st.ir_sh = `JTS_IR_CAPTURE;
                    end
                    jts_pkg::st_sh_ir: begin
                        // Holding the input high through the scan loads all ones
                        next_st.ir_sh = {sync_pins.tdi, st.ir_sh[`JTS_IR_W-1:1]};
                    end
                    jts_pkg::st_upd_ir: begin
                        next_st.ir = st.ir_sh;
                    end
                    jts_pkg::st_cap_dr: begin
                        if (sel_id(st.ir)) begin
                            next_st.dr_sh = ID_VALUE;
                        end else begin
                            next_st.dr_sh[0] = `JTS_BYPASS_CAP;
                        end
                    end
                    jts_pkg::st_sh_dr: begin
                        if (sel_id(st.ir)) begin
                            next_st.dr_sh = {sync_pins.tdi, st.dr_sh[`JTS_ID_W-1:1]};
                        end else begin
                            // One stage only, so the chain length stays fixed
                            next_st.dr_sh[0] = sync_pins.tdi;
                        end
                    end
                    default: begin
                        next_st.ir = st.ir;
                    end
                endcase
                next_st.tap = tap_next(st.tap, sync_pins.tms);
                // Instruction is forced on the very edge that enters reset, so the
                // port never sits in reset with a stale instruction
                if (next_st.tap == jts_pkg::st_reset) begin
                    next_st.ir = `JTS_IR_IDCODE;
                end
            end

            if (tck_fall) begin
                if (st.tap == jts_pkg::st_sh_ir) begin
                    next_st.pin_out.tdo  = st.ir_sh[0];
                    next_st.pin_oe_n.tdo = 1'b0;
                end else if (st.tap == jts_pkg::st_sh_dr) begin
                    next_st.pin_out.tdo  = st.dr_sh[0];
                    next_st.pin_oe_n.tdo = 1'b0;
                end else begin
                    next_st.pin_oe_n.tdo = 1'b1;
                end
            end else if (st.tap == jts_pkg::st_reset) begin
                // Covers the hand-back from general I/O without a clock edge
                next_st.pin_oe_n.tdo = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; power-up reset is the only reset input; TMS held high and cfg_jtag_off also put the port in reset

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.tap       <= jts_pkg::st_reset;
            st.ir        <= `JTS_IR_IDCODE;
            st.ir_sh     <= '0;
            st.dr_sh     <= '0;
            st.tck_prev  <= 1'b1;
            st.dedicated <= 1'b1;
            st.pin_out   <= '0;
            st.pin_oe_n  <= `JTS_SYNC_RESET;
            st.gpio_in   <= `JTS_SYNC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pin_out   = st.pin_out;
    assign pin_oe_n  = st.pin_oe_n;
    assign gpio_in   = st.gpio_in;
    assign tap_state = st.tap;
    assign instr     = st.ir;

endmodule
`default_nettype wire

// ---- tb/jts_master.sv ----
// Behavioural scan chain master driving the test clock, mode and data pins.
// Assumes the caller runs on ref_clk; test clock stands low between ticks.
`timescale 1ns/1ps
`default_nettype none
module jts_master (
    input  wire logic ref_clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic seen_bit;
    event seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One test clock of 200 ns: 4 cycles low, 4 high; TDO read just before the rise
    task tick(input logic m, input logic d, input logic c);
        @(posedge ref_clk);
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        seen_bit = tdo;
        if (c) ->seen;
        @(posedge ref_clk);
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/jts_tap_chk.sv ----
// Checks on test port timing, enables and pin sharing.
// Assumes it is bound onto jts_tap and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module jts_tap_chk (
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    input wire logic                    cfg_jtag_off,
    input wire jts_pkg::jts_pins_t      pin_in,
    input wire jts_pkg::jts_pins_t      pin_out,
    input wire jts_pkg::jts_pins_t      pin_oe_n,
    input wire jts_pkg::jts_pins_t      user_out,
    input wire jts_pkg::jts_pins_t      user_oe_n,
    input wire jts_pkg::jts_pins_t      gpio_in,
    input wire jts_pkg::jts_tap_state_t tap_state,
    input wire logic [3:0]              instr
);
    logic [3:0] off_h;
    logic       ded;
    // Mode switch takes a few edges to settle, so checks wait it out
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_h <= 4'hF;
        end else begin
            off_h <= {off_h[2:0], cfg_jtag_off};
        end
    end
    assign ded = !cfg_jtag_off && off_h == 4'h0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RST_INSTR: assert property (tap_state == jts_pkg::st_reset |->
        instr == 4'h1) else $error("reset instr bad");
    AST_RST_TDO_OFF: assert property ((ded && tap_state == jts_pkg::st_reset) [*2] |->
        pin_oe_n.tdo) else $error("tdo on in reset");
    AST_OE_SHIFT: assert property (ded && $fell(pin_oe_n.tdo) |->
        tap_state inside {jts_pkg::st_sh_ir, jts_pkg::st_sh_dr}) else $error("tdo on");
    AST_TDO_FALL: assert property (ded && $changed(pin_out.tdo) |->
        !$past(pin_in.tck, 3) && $past(pin_in.tck, 4)) else $error("tdo edge");
    AST_STATE_RISE: assert property (ded && $changed(tap_state) |->
        $past(pin_in.tck, 3) && !$past(pin_in.tck, 4)) else $error("state edge");
    AST_SHDR_EXIT: assert property (ded && $past(tap_state) == jts_pkg::st_sh_dr
        && tap_state != jts_pkg::st_sh_dr |-> tap_state == jts_pkg::st_ex1_dr) else $error("exit");
    AST_GPIO_OUT: assert property (cfg_jtag_off [*3] |-> pin_out == $past(user_out)
        && pin_oe_n == $past(user_oe_n)) else $error("gpio out");
    AST_GPIO_IN: assert property ($past(rst_n, 3) |-> gpio_in == $past(pin_in, 3))
        else $error("gpio in");
endmodule
bind jts_tap jts_tap_chk i_jts_tap_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg_jtag_off(cfg_jtag_off), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .user_out(user_out), .user_oe_n(user_oe_n), .gpio_in(gpio_in), .tap_state(tap_state),
    .instr(instr));
`default_nettype wire

// ---- tb/jts_tap_subset_bench.sv ----
// Self-checking bench: scans through the test port, then pin sharing.
// Assumes a pull-up on the TDO pin when it is released.
`timescale 1ns/1ps
`default_nettype none
module jts_tap_subset_bench;
    localparam logic [31:0] ID = 32'h1357_9BD5; // Arbitrary value
    logic                    ref_clk = 0, rst_n = 0, cfg_jtag_off = 0, tck, tms, tdi;
    jts_pkg::jts_pins_t      pin_in, pin_out, pin_oe_n, gpio_in, user_out = '0, user_oe_n = '1;
    jts_pkg::jts_tap_state_t tap_state;
    logic [3:0]              instr;
    logic [32:0]             d;
    logic                    q[$];
    int                      miscompares = 0, checked = 0;
    assign pin_in = {tck, tms, tdi, pin_oe_n.tdo ? 1'b1 : pin_out.tdo};
    jts_tap #(.ID_VALUE(ID)) i_jts_tap (.ref_clk(ref_clk), .rst_n(rst_n),
        .cfg_jtag_off(cfg_jtag_off), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .user_out(user_out), .user_oe_n(user_oe_n), .gpio_in(gpio_in), .tap_state(tap_state),
        .instr(instr));
    jts_master i_jts_master (.ref_clk(ref_clk), .tdo(pin_in.tdo), .tck(tck), .tms(tms), .tdi(tdi));
    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] s, input logic [31:0] e, input string n);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task close_out();
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Scan from idle back to idle; expected TDO bits are queued LSB first
    task scan(input logic ir, input int n, input logic [32:0] din, input logic [32:0] ex);
        i_jts_master.tick(1, 0, 0);
        if (ir) i_jts_master.tick(1, 0, 0);
        repeat (2) i_jts_master.tick(0, 0, 0);
        for (int i = 0; i < n; i++) begin
            q.push_back(ex[i]);
            i_jts_master.tick(i == n - 1, din[i], 1);
        end
        i_jts_master.tick(1, 0, 0);
        i_jts_master.tick(0, 0, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial forever #12.5 ref_clk = ~ref_clk;
    initial forever begin
        @(i_jts_master.seen);
        cmp(i_jts_master.seen_bit, q.pop_front(), "tdo");
    end
    initial begin
        #500us;
        miscompares++;
        close_out();
    end
    initial begin
        void'($urandom(50));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cmp(tap_state, jts_pkg::st_reset, "state");
        cmp(instr, 4'h1, "instr");
        cmp(pin_oe_n, 4'hF, "oe_n");
        i_jts_master.tick(0, 0, 0);
        scan(0, 32, 33'(32'($urandom())), 33'(ID));
        scan(1, 4, 33'h0F, 33'h1);
        cmp(instr, 4'hF, "instr");
        d = 33'(32'($urandom()));
        scan(0, 33, d, {d[31:0], 1'b0});
        cmp(pin_oe_n.tdo, 1'b1, "tdo oe_n");
        for (int c = 0; c < 16; c++) begin
            scan(1, 4, 33'(c[3:0]), 33'h1);
            cmp(instr, 32'(c[3:0]), "instr");
            scan(0, 2, 33'h3, (c == 1) ? 33'(ID[1:0]) : 33'h2);
        end
        repeat (5) i_jts_master.tick(1, 0, 0);
        cmp(tap_state, jts_pkg::st_reset, "state");
        cmp(instr, 4'h1, "instr");
        @(posedge ref_clk);
        cfg_jtag_off <= 1'b1;
        user_out <= 4'($urandom());
        user_oe_n <= 4'($urandom());
        // Pin levels reach the fabric five edges after the user values land
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp(pin_out, user_out, "gpio out");
        cmp(pin_oe_n, user_oe_n, "gpio oe_n");
        cmp(gpio_in, pin_in, "gpio in");
        @(posedge ref_clk);
        cfg_jtag_off <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp(pin_oe_n, 4'hF, "oe_n");
        cmp(tap_state, jts_pkg::st_reset, "state");
        cmp(instr, 4'h1, "instr");
        close_out();
    end
endmodule
`default_nettype wire
